// ==== hw/tol_pkg.sv ====
// constants for the temperature offset, limit and result register block
package tol_pkg;
   // register pointers
   localparam logic [7:0] ADR_CFG1      = 8'h00;
   localparam logic [7:0] ADR_CFG2      = 8'h01;
   localparam logic [7:0] ADR_CFG3      = 8'h02;
   localparam logic [7:0] ADR_REM_FRAC  = 8'h08;
   localparam logic [7:0] ADR_LOC_FRAC  = 8'h09;
   localparam logic [7:0] ADR_TH1_VAL   = 8'h0A;
   localparam logic [7:0] ADR_TH2_VAL   = 8'h0B;
   localparam logic [7:0] ADR_REM_VAL   = 8'h0D;
   localparam logic [7:0] ADR_LOC_VAL   = 8'h0E;
   localparam logic [7:0] ADR_STATUS    = 8'h10;
   localparam logic [7:0] ADR_ALERT_EN  = 8'h12;
   localparam logic [7:0] ADR_TH1_LO    = 8'h14;
   localparam logic [7:0] ADR_TH1_HI    = 8'h15;
   localparam logic [7:0] ADR_TH2_LO    = 8'h16;
   localparam logic [7:0] ADR_TH2_HI    = 8'h17;
   localparam logic [7:0] ADR_REM_LO    = 8'h1A;
   localparam logic [7:0] ADR_REM_HI    = 8'h1B;
   localparam logic [7:0] ADR_LOC_LO    = 8'h1C;
   localparam logic [7:0] ADR_LOC_HI    = 8'h1D;
   localparam logic [7:0] ADR_TH1_OFS   = 8'h24;
   localparam logic [7:0] ADR_TH2_OFS   = 8'h25;
   localparam logic [7:0] ADR_REM_OFS   = 8'h26;
   localparam logic [7:0] ADR_LOC_OFS   = 8'h27;
   // reset values
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_DIODE_HI  = 8'h7F;
   localparam logic [7:0] RST_THERM_HI  = 8'hFF;
   localparam logic [7:0] RST_ALERT_EN  = 8'h0F;
   // field positions
   localparam int CFG1_RANGE_BIT = 7;
   localparam int CFG2_NORM_BIT  = 0;
   localparam int CFG3_TH1_BIT   = 6;
   localparam int CFG3_TH2_BIT   = 7;
   // channel numbers
   localparam logic [1:0] CH_TH1 = 2'h0;
   localparam logic [1:0] CH_TH2 = 2'h1;
   localparam logic [1:0] CH_REM = 2'h2;
   localparam logic [1:0] CH_LOC = 2'h3;
   // result format, quarter-degree units
   localparam logic signed [13:0] RANGE_SHIFT_Q = 14'h0100;
   localparam logic signed [13:0] BIN_MAX_Q     = 14'h01FF;
   localparam logic signed [13:0] OFB_MAX_Q     = 14'h03FF;
   // thermistor normalisation: q = (code * gain) >> shift - bias
   localparam logic [7:0]  NORM_GAIN_10K  = 8'h80;
   localparam logic [7:0]  NORM_GAIN_100K = 8'h60;
   localparam logic [13:0] NORM_BIAS_10K  = 14'h0040;
   localparam logic [13:0] NORM_BIAS_100K = 14'h0020;
   localparam int          NORM_SHIFT     = 7;
   // serial port
   localparam logic [6:0] SMB_DEV_ADDR = 7'h2C; // arbitrary value
   localparam logic [3:0] SMB_BYTE_END = 4'h8;
   localparam logic [3:0] SMB_BIT_ONE  = 4'h1;
   localparam logic [3:0] SMB_BIT_ZERO = 4'h0;
endpackage : tol_pkg

// ==== hw/tol_regs.sv ====
// temperature offset, limit check, result registers and serial slave
`timescale 1ns/1ps
module tol_regs
   import tol_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_sda_out,
   output logic             o_sda_oe_n,
   output logic             o_alert_out,
   output logic             o_alert_oe_n,
   input  wire logic        i_conv_valid,
   input  wire logic [1:0]  i_conv_chan,
   input  wire logic [11:0] i_conv_data
);

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_ADDR  = 6'h02,
      ST_RX    = 6'h04,
      ST_ACK   = 6'h08,
      ST_TX    = 6'h10,
      ST_TXACK = 6'h20
   } tol_smb_state_type;

   tol_smb_state_type st_q;
   logic [2:0]  scl_s_q;
   logic [2:0]  sda_s_q;
   logic        scl_f_q;
   logic        sda_f_q;
   logic [3:0]  cnt_q;
   logic [7:0]  sh_q;
   logic [7:0]  ptr_q;
   logic        rw_q;
   logic        first_q;
   logic        drive_q;
   logic        wr_stb_q;
   logic [7:0]  cfg1_q;
   logic [7:0]  cfg2_q;
   logic [7:0]  cfg3_q;
   logic [7:0]  alert_en_q;
   logic [7:0]  lo_q   [4];
   logic [7:0]  hi_q   [4];
   logic [7:0]  ofs_q  [4];
   logic [9:0]  res_q  [4];
   logic [9:0]  snap_q [4];
   logic [3:0]  stat_q;
   logic        frz_q;
   logic [3:0]  pend_q;
   logic        alert_n_q;
   logic        scl_agree;
   logic        sda_agree;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_ev;
   logic        stop_ev;
   logic        rd_go;
   logic [7:0]  rdata;
   logic        conv_th;
   logic [9:0]  conv_res;

   assign o_sda_out    = 1'b0;
   assign o_sda_oe_n   = ~drive_q;
   assign o_alert_out  = 1'b0;
   assign o_alert_oe_n = alert_n_q;

   // offset, range shift and thermistor scaling with clamping
   function automatic logic [9:0] tol_convert(input logic [11:0] raw, input logic is_th,
                                             input logic n10k, input logic ofb,
                                             input logic [7:0] ofs);
      logic [17:0]        p;
      logic signed [13:0] t;
      logic signed [13:0] mx;
      p  = 18'(raw[9:0]) * 18'(n10k ? NORM_GAIN_10K : NORM_GAIN_100K);
      mx = ofb ? OFB_MAX_Q : BIN_MAX_Q;
      if (is_th) begin
         t = $signed(14'(p >> NORM_SHIFT)) - $signed(n10k ? NORM_BIAS_10K : NORM_BIAS_100K);
      end else begin
         t = $signed({{2{raw[11]}}, raw});
      end
      if (ofb) begin
         t = t + RANGE_SHIFT_Q;
      end
      t = t + $signed({{4{ofs[7]}}, ofs, 2'b00});
      if (t < 0) begin
         t = '0;
      end else if (t > mx) begin
         t = mx;
      end
      return t[9:0];
   endfunction : tol_convert

   // limits are compared against the integer byte only
   function automatic logic tol_out_of_limit(input logic [9:0] r, input logic [7:0] lo,
                                            input logic [7:0] hi);
      return (r[9:2] > hi) || (r[9:2] <= lo);
   endfunction : tol_out_of_limit

   function automatic logic [3:0] tol_frz_bit(input logic [7:0] a);
      case (a)
         ADR_REM_FRAC: return 4'h1;
         ADR_LOC_FRAC: return 4'h2;
         ADR_REM_VAL:  return 4'h4;
         ADR_LOC_VAL:  return 4'h8;
         default:      return 4'h0;
      endcase
   endfunction : tol_frz_bit

   // ---------------- pin synchronisers ----------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], i_scl};
         sda_s_q <= {sda_s_q[1:0], i_sda};
         if (scl_agree) begin
            scl_f_q <= scl_s_q[2];
         end
         if (sda_agree) begin
            sda_f_q <= sda_s_q[2];
         end
      end
   end

   assign scl_agree = scl_s_q[1] == scl_s_q[2];
   assign sda_agree = sda_s_q[1] == sda_s_q[2];
   assign scl_rise  = scl_agree && scl_s_q[2] && !scl_f_q;
   assign scl_fall  = scl_agree && !scl_s_q[2] && scl_f_q;
   assign start_ev  = sda_agree && !sda_s_q[2] && sda_f_q && scl_f_q;
   assign stop_ev   = sda_agree && sda_s_q[2] && !sda_f_q && scl_f_q;
   assign rd_go     = scl_fall && ((st_q == ST_ACK && rw_q) || st_q == ST_TXACK);

   // ---------------- serial slave ----------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q     <= ST_IDLE;
         cnt_q    <= SMB_BIT_ZERO;
         sh_q     <= RST_ZERO;
         ptr_q    <= RST_ZERO;
         rw_q     <= 1'b0;
         first_q  <= 1'b0;
         drive_q  <= 1'b0;
         wr_stb_q <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         if (stop_ev) begin
            st_q    <= ST_IDLE;
            drive_q <= 1'b0;
         end else if (start_ev) begin
            st_q    <= ST_ADDR;
            cnt_q   <= SMB_BIT_ZERO;
            first_q <= 1'b1;
            drive_q <= 1'b0;
         end else if (rd_go) begin
            // a read always returns the byte at the current pointer
            sh_q    <= rdata;
            drive_q <= ~rdata[7];
            cnt_q   <= SMB_BIT_ONE;
            st_q    <= ST_TX;
         end else begin
            case (st_q)
               ST_ADDR, ST_RX: begin
                  if (scl_rise && cnt_q != SMB_BYTE_END) begin
                     sh_q  <= {sh_q[6:0], sda_f_q};
                     cnt_q <= cnt_q + SMB_BIT_ONE;
                  end else if (scl_fall && cnt_q == SMB_BYTE_END) begin
                     cnt_q <= SMB_BIT_ZERO;
                     if (st_q == ST_ADDR) begin
                        if (sh_q[7:1] == SMB_DEV_ADDR) begin
                           drive_q <= 1'b1;
                           rw_q    <= sh_q[0];
                           st_q    <= ST_ACK;
                        end else begin
                           st_q <= ST_IDLE;
                        end
                     end else begin
                        drive_q <= 1'b1;
                        st_q    <= ST_ACK;
                        if (first_q) begin
                           ptr_q   <= sh_q;
                           first_q <= 1'b0;
                        end else begin
                           wr_stb_q <= 1'b1;
                        end
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     drive_q <= 1'b0;
                     st_q    <= ST_RX;
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (cnt_q == SMB_BYTE_END) begin
                        drive_q <= 1'b0;
                        st_q    <= ST_TXACK;
                     end else begin
                        drive_q <= ~sh_q[6];
                        sh_q    <= {sh_q[6:0], 1'b0};
                        cnt_q   <= cnt_q + SMB_BIT_ONE;
                     end
                  end
               end
               ST_TXACK: begin
                  // master not-acknowledge ends the read
                  if (scl_rise && sda_f_q) begin
                     st_q <= ST_IDLE;
                  end
               end
               ST_IDLE: begin
                  drive_q <= 1'b0;
               end
               default: begin
                  st_q    <= ST_IDLE;
                  drive_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ---------------- read mux ----------------
   always_comb begin
      rdata = RST_ZERO;
      case (ptr_q)
         ADR_CFG1:     rdata = cfg1_q;
         ADR_CFG2:     rdata = cfg2_q;
         ADR_CFG3:     rdata = cfg3_q;
         ADR_REM_FRAC: rdata = {6'h00, frz_q ? snap_q[CH_REM][1:0] : res_q[CH_REM][1:0]};
         ADR_LOC_FRAC: rdata = {6'h00, frz_q ? snap_q[CH_LOC][1:0] : res_q[CH_LOC][1:0]};
         ADR_REM_VAL:  rdata = frz_q ? snap_q[CH_REM][9:2] : res_q[CH_REM][9:2];
         ADR_LOC_VAL:  rdata = frz_q ? snap_q[CH_LOC][9:2] : res_q[CH_LOC][9:2];
         ADR_TH1_VAL:  rdata = res_q[CH_TH1][9:2];
         ADR_TH2_VAL:  rdata = res_q[CH_TH2][9:2];
         ADR_STATUS:   rdata = {4'h0, stat_q};
         ADR_ALERT_EN: rdata = alert_en_q;
         ADR_TH1_LO:   rdata = lo_q[CH_TH1];
         ADR_TH1_HI:   rdata = hi_q[CH_TH1];
         ADR_TH2_LO:   rdata = lo_q[CH_TH2];
         ADR_TH2_HI:   rdata = hi_q[CH_TH2];
         ADR_REM_LO:   rdata = lo_q[CH_REM];
         ADR_REM_HI:   rdata = hi_q[CH_REM];
         ADR_LOC_LO:   rdata = lo_q[CH_LOC];
         ADR_LOC_HI:   rdata = hi_q[CH_LOC];
         ADR_TH1_OFS:  rdata = ofs_q[CH_TH1];
         ADR_TH2_OFS:  rdata = ofs_q[CH_TH2];
         ADR_REM_OFS:  rdata = ofs_q[CH_REM];
         ADR_LOC_OFS:  rdata = ofs_q[CH_LOC];
         default:      rdata = RST_ZERO;
      endcase
   end

   // ---------------- writable registers ----------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg1_q     <= RST_ZERO;
         cfg2_q     <= RST_ZERO;
         cfg3_q     <= RST_ZERO;
         alert_en_q <= RST_ALERT_EN;
         for (int i = 0; i < 4; i++) begin
            lo_q[i]  <= RST_ZERO;
            ofs_q[i] <= RST_ZERO;
         end
         hi_q[CH_TH1] <= RST_THERM_HI;
         hi_q[CH_TH2] <= RST_THERM_HI;
         hi_q[CH_REM] <= RST_DIODE_HI;
         hi_q[CH_LOC] <= RST_DIODE_HI;
      end else if (wr_stb_q) begin
         case (ptr_q)
            ADR_CFG1:     cfg1_q         <= sh_q;
            ADR_CFG2:     cfg2_q         <= sh_q;
            ADR_CFG3:     cfg3_q         <= sh_q;
            ADR_ALERT_EN: alert_en_q     <= sh_q;
            ADR_TH1_LO:   lo_q[CH_TH1]   <= sh_q;
            ADR_TH1_HI:   hi_q[CH_TH1]   <= sh_q;
            ADR_TH2_LO:   lo_q[CH_TH2]   <= sh_q;
            ADR_TH2_HI:   hi_q[CH_TH2]   <= sh_q;
            ADR_REM_LO:   lo_q[CH_REM]   <= sh_q;
            ADR_REM_HI:   hi_q[CH_REM]   <= sh_q;
            ADR_LOC_LO:   lo_q[CH_LOC]   <= sh_q;
            ADR_LOC_HI:   hi_q[CH_LOC]   <= sh_q;
            ADR_TH1_OFS:  ofs_q[CH_TH1]  <= sh_q;
            ADR_TH2_OFS:  ofs_q[CH_TH2]  <= sh_q;
            ADR_REM_OFS:  ofs_q[CH_REM]  <= sh_q;
            ADR_LOC_OFS:  ofs_q[CH_LOC]  <= sh_q;
            default: ;
         endcase
      end
   end

   // ---------------- conversion results and limit status ----------------
   assign conv_th  = (i_conv_chan == CH_TH1) ? cfg3_q[CFG3_TH1_BIT] :
                     (i_conv_chan == CH_TH2) ? cfg3_q[CFG3_TH2_BIT] : 1'b0;
   assign conv_res = tol_convert(i_conv_data, conv_th, cfg2_q[CFG2_NORM_BIT],
                                 cfg1_q[CFG1_RANGE_BIT], ofs_q[i_conv_chan]);

   // status follows the latest comparison; limit checks always see live data
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 4; i++) begin
            res_q[i] <= '0;
         end
         stat_q <= 4'h0;
      end else if (i_conv_valid) begin
         res_q[i_conv_chan]  <= conv_res;
         stat_q[i_conv_chan] <= tol_out_of_limit(conv_res, lo_q[i_conv_chan],
                                                 hi_q[i_conv_chan]);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alert_n_q <= 1'b1;
      end else begin
         alert_n_q <= ~|(stat_q & alert_en_q[3:0]);
      end
   end

   // ---------------- read coherence freeze ----------------
   // the snapshot is taken on the same edge that loads the read byte
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         frz_q  <= 1'b0;
         pend_q <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            snap_q[i] <= '0;
         end
      end else if (rd_go) begin
         if (!frz_q) begin
            if (ptr_q == ADR_REM_FRAC || ptr_q == ADR_LOC_FRAC) begin
               frz_q  <= 1'b1;
               pend_q <= 4'hF & ~tol_frz_bit(ptr_q);
               snap_q <= res_q;
            end
         end else begin
            pend_q <= pend_q & ~tol_frz_bit(ptr_q);
            if ((pend_q & ~tol_frz_bit(ptr_q)) == 4'h0) begin
               frz_q <= 1'b0;
            end
         end
      end
   end

   // ---------------- checks ----------------
   sequence frz_start_s;
      rd_go && !frz_q && (ptr_q == ADR_REM_FRAC || ptr_q == ADR_LOC_FRAC);
   endsequence

   // the snapshot is loaded on the entry edge, so it must equal the results held just before
   sequence frz_held_s;
      frz_q && snap_q[CH_REM] == $past(res_q[CH_REM]);
   endsequence

   freeze_entry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      frz_start_s |=> frz_held_s)
      else $error("fraction read did not freeze results");

   freeze_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (frz_q && $past(frz_q)) |-> $stable(snap_q[CH_LOC]) && $stable(snap_q[CH_REM]))
      else $error("frozen snapshot changed");

   freeze_exit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $fell(frz_q) |-> pend_q == 4'h0)
      else $error("freeze released with reads pending");

   offset_sum_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_conv_valid && i_conv_chan == CH_REM && !cfg1_q[CFG1_RANGE_BIT]
       && $signed({{2{i_conv_data[11]}}, i_conv_data})
          + $signed({{4{ofs_q[CH_REM][7]}}, ofs_q[CH_REM], 2'b00}) >= 0
       && $signed({{2{i_conv_data[11]}}, i_conv_data})
          + $signed({{4{ofs_q[CH_REM][7]}}, ofs_q[CH_REM], 2'b00}) <= BIN_MAX_Q)
      |=> res_q[CH_REM] == 10'($past(i_conv_data)
                                + {{2{$past(ofs_q[CH_REM][7])}}, $past(ofs_q[CH_REM]), 2'b00}))
      else $error("offset not added to remote result");

   binary_clamp_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_conv_valid && !cfg1_q[CFG1_RANGE_BIT]) |=> res_q[$past(i_conv_chan)] <= 10'h1FF)
      else $error("binary result above format maximum");

   limit_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_conv_valid |=> stat_q[$past(i_conv_chan)]
         == ((res_q[$past(i_conv_chan)][9:2] > $past(hi_q[i_conv_chan]))
             || (res_q[$past(i_conv_chan)][9:2] <= $past(lo_q[i_conv_chan]))))
      else $error("status bit disagrees with limit comparison");

   alert_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      |(stat_q & alert_en_q[3:0]) |=> !o_alert_oe_n)
      else $error("enabled out-of-limit status did not pull alert");

   addr_ack_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (st_q == ST_ADDR && scl_fall && cnt_q == SMB_BYTE_END && sh_q[7:1] == SMB_DEV_ADDR
       && !start_ev && !stop_ev) |=> !o_sda_oe_n && st_q == ST_ACK)
      else $error("own address not acknowledged");

   therm_norm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_conv_valid && i_conv_chan == CH_TH2 && cfg3_q[CFG3_TH2_BIT]
       && ofs_q[CH_TH2] == RST_ZERO && !cfg1_q[CFG1_RANGE_BIT] && i_conv_data[9:0] == 10'h000)
      |=> res_q[CH_TH2] == 10'h000)
      else $error("thermistor zero code not clamped to zero");

endmodule : tol_regs

// ==== tb/tol_host.sv ====
// two-wire bus host model that reaches the block's registers
`timescale 1ns/1ps
module tol_host
   import tol_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe_n
);
   localparam int HALF = 4;
   initial begin
      o_scl      = 1'b1;
      o_sda_oe_n = 1'b1;
   end
   task automatic wt();
      repeat (HALF) @(negedge i_clk);
   endtask : wt
   // a low enable pulls the open-drain line; the pull-up restores it
   task automatic bt(input logic b, output logic r);
      o_sda_oe_n = b;
      wt();
      o_scl = 1'b1;
      wt();
      r = i_sda;
      o_scl = 1'b0;
      // data moves two cycles after the fall, so the fall clears the filter first, else it reads as start or stop
      repeat (2) @(negedge i_clk);
   endtask : bt
   task automatic start();
      o_sda_oe_n = 1'b1;
      wt();
      o_scl = 1'b1;
      wt();
      o_sda_oe_n = 1'b0;
      wt();
      o_scl = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask : start
   task automatic by(input logic [7:0] v, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bt(v[i], r[i]);
      bt(1'b1, a);
   endtask : by
   // reads end with a not-acknowledge so the slave lets the line go
   task automatic xfer(input logic rd, input logic [7:0] p, input logic [7:0] wv,
                       output logic [7:0] rv, output logic nak);
      logic [7:0] r;
      logic       a;
      start();
      by({SMB_DEV_ADDR, 1'b0}, r, nak);
      by(p, r, a);
      nak |= a;
      if (rd) begin
         start();
         by({SMB_DEV_ADDR, 1'b1}, r, a);
         nak |= a;
         by(8'hff, rv, a);
      end else begin
         by(wv, r, a);
         nak |= a;
      end
      o_sda_oe_n = 1'b0;
      wt();
      o_scl = 1'b1;
      wt();
      o_sda_oe_n = 1'b1;
      wt();
   endtask : xfer
endmodule : tol_host

// ==== tb/testbench.sv ====
// self-checking bench for the offset, limit and result register block
`timescale 1ns/1ps
module testbench;
   import tol_pkg::*;
   logic        i_clk, i_rst_n, i_conv_valid, dev_oe_n, dev_out, host_oe_n, scl, alert_oe_n;
   logic        alert_out;
   logic [1:0]  i_conv_chan;
   logic [11:0] i_conv_data;
   wire         sda_wire;
   int          error_cnt, checks_done, v;
   logic [9:0]  res[4];
   logic        flag[4];
   logic [7:0]  ofsv[4];
   logic [7:0]  lo_l, hi_l, b;
   bit          ofb;
   logic [1:0]  ch;
   localparam logic [7:0] RA[17] = '{8'h08, 8'h09, 8'h0d, 8'h0e, 8'h14, 8'h15, 8'h16, 8'h17,
      8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h24, 8'h25, 8'h26, 8'h27, 8'h30};
   localparam logic [7:0] RV[17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff,
      8'h00, 8'h7f, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam int CORNER[6] = '{387, 388, 67, 68, 2047, -2048};
   // open drain: either party pulling low wins over the pull-up
   assign sda_wire = (dev_oe_n | dev_out) & host_oe_n;
   tol_regs uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_wire),
      .o_sda_out(dev_out), .o_sda_oe_n(dev_oe_n), .o_alert_out(alert_out),
      .o_alert_oe_n(alert_oe_n),
      .i_conv_valid(i_conv_valid), .i_conv_chan(i_conv_chan), .i_conv_data(i_conv_data));
   tol_host host (.i_clk(i_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_oe_n(host_oe_n));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic conclude();
      if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] r;
      logic       n;
      host.xfer(1'b0, p, d, r, n);
      chk(n, 0);
   endtask : wr
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic n;
      host.xfer(1'b1, p, 8'h00, d, n);
      chk(n, 0);
   endtask : rd
   function automatic logic [9:0] expr(input int q, input logic [7:0] o);
      int s;
      s = q + (ofb ? 256 : 0) + 4 * $signed(o);
      if (s < 0) s = 0;
      if (s > (ofb ? 1023 : 511)) s = ofb ? 1023 : 511;
      return s[9:0];
   endfunction : expr
   task automatic conv(input logic [1:0] c, input int d, input int q);
      i_conv_chan = c;
      i_conv_data = d[11:0];
      i_conv_valid = 1'b1;
      @(negedge i_clk);
      i_conv_valid = 1'b0;
      res[c] = expr(q, ofsv[c]);
      flag[c] = res[c][9:2] > hi_l || res[c][9:2] <= lo_l;
      @(negedge i_clk);
      if (c[1]) chk(alert_oe_n, !(flag[2] | flag[3]));
      chk(alert_out, 0);
   endtask : conv
   initial begin
      repeat (95000) @(posedge i_clk);
      error_cnt++;
      conclude();
   end
   initial begin
      logic [9:0] snap[4];
      {i_rst_n, i_conv_valid, i_conv_chan, i_conv_data, ofb} = '0;
      res = '{4{10'h000}};
      flag = '{4{1'b0}};
      ofsv = '{4{8'h00}};
      void'($urandom(32'h3f6e_fc89));
      repeat (20) @(negedge i_clk);
      i_rst_n = 1'b1;
      repeat (5) @(negedge i_clk);
      for (int i = 0; i < 17; i++) begin
         rd(RA[i], b);
         chk(b, RV[i]);
      end
      for (int i = 4; i < 16; i++) begin
         v = $urandom;
         wr(RA[i], v[7:0]);
         // offsets written here stay in force until the later loops write new ones
         if (i >= 12) ofsv[i - 12] = v[7:0];
         rd(RA[i], b);
         chk(b, v[7:0]);
      end
      wr(ADR_REM_VAL, 8'h5a);
      rd(ADR_REM_VAL, b);
      chk(b, 0);
      for (int m = 0; m < 2; m++) begin
         ofb = m[0];
         wr(ADR_CFG1, {ofb, 7'h00});
         lo_l = 8'h10 + (ofb ? 8'h40 : 8'h00);
         hi_l = 8'h60 + (ofb ? 8'h40 : 8'h00);
         for (int i = 8; i < 12; i++) wr(RA[i], i[0] ? hi_l : lo_l);
         for (int i = 0; i < 10; i++) begin
            ch = 2'd2 + 2'($urandom_range(0, 1));
            v = (i < 6) ? CORNER[i] : int'($urandom_range(0, 1700)) - 300;
            ofsv[ch] = (i < 6) ? 8'h00 : 8'($urandom);
            wr(ch[0] ? ADR_LOC_OFS : ADR_REM_OFS, ofsv[ch]);
            conv(ch, v, v);
            snap = res;
            // results arriving between the two halves must not tear the pair
            rd(ADR_REM_FRAC, b);
            chk(b[1:0], snap[2][1:0]);
            v = int'($urandom_range(0, 1700)) - 300;
            conv({1'b1, v[0]}, v, v);
            rd(ADR_LOC_FRAC, b);
            chk(b[1:0], snap[3][1:0]);
            rd(ADR_REM_VAL, b);
            chk(b, snap[2][9:2]);
            rd(ADR_LOC_VAL, b);
            chk(b, snap[3][9:2]);
            rd(ADR_REM_VAL, b);
            chk(b, res[2][9:2]);
            rd(ADR_STATUS, b);
            chk(|b[3:0], flag[2] | flag[3]);
         end
      end
      // thermistor last: its limits would otherwise disturb the alert checks
      ofb = 1'b0;
      wr(ADR_CFG1, 8'h00);
      wr(ADR_CFG3, 8'hc0);
      ofsv[0] = 8'($urandom_range(0, 8));
      wr(ADR_TH1_OFS, ofsv[0]);
      ofsv[1] = 8'h00;
      wr(ADR_TH2_OFS, ofsv[1]);
      for (int n = 0; n < 2; n++) begin
         wr(ADR_CFG2, 8'(n));
         v = $urandom_range(0, 1023);
         conv(2'd0, v, n ? int'((v * NORM_GAIN_10K) >> NORM_SHIFT) - int'(NORM_BIAS_10K)
                         : int'((v * NORM_GAIN_100K) >> NORM_SHIFT) - int'(NORM_BIAS_100K));
         rd(ADR_TH1_VAL, b);
         chk(b, res[0][9:2]);
         // a zero code normalises below zero and must clamp
         conv(2'd1, 0, n ? -int'(NORM_BIAS_10K) : -int'(NORM_BIAS_100K));
         rd(ADR_TH2_VAL, b);
         chk(b, res[1][9:2]);
      end
      conclude();
   end
endmodule : testbench
